// >>> pkg/tmsq_pkg.sv
// Package with register map, field layouts and state carrier of the timer mode sequencer.
package tmsq_pkg;

	// ==========================================================
	// Register byte offsets on the AHB-Lite bus.
	localparam logic [7:0] OFS_CTRL  = 8'h00; // Mode, output and prescaler control.
	localparam logic [7:0] OFS_COUNT = 8'h04; // Counter value.
	localparam logic [7:0] OFS_CMPA  = 8'h08; // Compare A value.
	localparam logic [7:0] OFS_CMPB  = 8'h0C; // Compare B value.
	localparam logic [7:0] OFS_CAPT  = 8'h10; // Capture register used as TOP.
	localparam logic [7:0] OFS_FLAGS = 8'h14; // Sticky flags, write one to clear.

	// ==========================================================
	// Counter constants.
	localparam logic [15:0] CNT_MAX    = 16'hFFFF; // Largest count.
	localparam logic [15:0] CNT_BOTTOM = 16'h0000; // Restart value.
	localparam logic [15:0] CNT_ONE    = 16'h0001; // Increment step.
	localparam logic [15:0] TOP_8BIT   = 16'h00FF; // Fixed TOP, mode 5.
	localparam logic [15:0] TOP_9BIT   = 16'h01FF; // Fixed TOP, mode 6.
	localparam logic [15:0] TOP_10BIT  = 16'h03FF; // Fixed TOP, mode 7.

	// ==========================================================
	// Waveform mode codes that the sequencer treats specially.
	localparam logic [3:0] MODE_NORMAL   = 4'h0; // Free running.
	localparam logic [3:0] MODE_CTC_CMPA = 4'h4; // Clear on compare A.
	localparam logic [3:0] MODE_FAST_8   = 4'h5; // Fast PWM, 8 bit.
	localparam logic [3:0] MODE_FAST_9   = 4'h6; // Fast PWM, 9 bit.
	localparam logic [3:0] MODE_FAST_10  = 4'h7; // Fast PWM, 10 bit.
	localparam logic [3:0] MODE_CTC_CAPT = 4'hC; // Clear on capture register.
	localparam logic [3:0] MODE_FAST_CAP = 4'hE; // Fast PWM, TOP from capture.
	localparam logic [3:0] MODE_FAST_CMP = 4'hF; // Fast PWM, TOP from compare A.

	// Compare output action codes.
	localparam logic [1:0] ACT_NONE   = 2'h0; // Output untouched.
	localparam logic [1:0] ACT_TOGGLE = 2'h1; // Toggle on match.
	localparam logic [1:0] ACT_CLEAR  = 2'h2; // Clear, or non-inverted PWM.
	localparam logic [1:0] ACT_SET    = 2'h3; // Set, or inverted PWM.

	// Prescaler selection codes; zero stops the timer.
	localparam logic [2:0] PSC_STOP = 3'h0; // No ticks.
	localparam logic [2:0] PSC_1    = 3'h1; // Divide by 1.
	localparam logic [2:0] PSC_8    = 3'h2; // Divide by 8.
	localparam logic [2:0] PSC_64   = 3'h3; // Divide by 64.
	localparam logic [2:0] PSC_256  = 3'h4; // Divide by 256.
	localparam logic [9:0] DIV_8    = 10'h007; // Last divider state for 8.
	localparam logic [9:0] DIV_64   = 10'h03F; // Last divider state for 64.
	localparam logic [9:0] DIV_256  = 10'h0FF; // Last divider state for 256.
	localparam logic [9:0] DIV_1024 = 10'h3FF; // Last divider state for 1024.

	// Flag bit positions.
	localparam int FLG_OVF  = 0; // Overflow flag.
	localparam int FLG_CMPA = 1; // Compare A flag.
	localparam int FLG_CMPB = 2; // Compare B flag.
	localparam int FLG_CAPT = 3; // Capture flag.
	localparam int CTRL_W   = 15; // Width of the control register.

	// ==========================================================
	// Control register layout, most significant field first.
	typedef struct packed {
		logic [2:0] presc;   // Prescaler selection.
		logic       dir_b;   // Pin direction bit, channel B.
		logic       dir_a;   // Pin direction bit, channel A.
		logic       route_b; // Output pin route enable, channel B.
		logic       route_a; // Output pin route enable, channel A.
		logic [1:0] act_b;   // Compare output action, channel B.
		logic [1:0] act_a;   // Compare output action, channel A.
		logic [3:0] mode;    // Waveform mode selection.
	} tmsq_ctrl_t;

	// Whole state of the sequencer.
	typedef struct packed {
		tmsq_ctrl_t  ctrl;     // Control fields.
		logic [15:0] cnt;      // Counter.
		logic [15:0] cmpa_act; // Active compare A.
		logic [15:0] cmpa_buf; // Buffered compare A.
		logic [15:0] cmpb_act; // Active compare B.
		logic [15:0] cmpb_buf; // Buffered compare B.
		logic [15:0] capt;     // Capture register.
		logic [3:0]  flags;    // Sticky flags.
		logic        blk;      // Match blocking after a count write.
		logic [9:0]  div;      // Prescaler divider.
		logic        oc_a;     // Compare output state A.
		logic        oc_b;     // Compare output state B.
		logic        oe_a_n;   // Pin A enable, low while driving.
		logic        oe_b_n;   // Pin B enable, low while driving.
		logic        dph;      // Data phase pending.
		logic        dwr;      // Pending phase is a write.
		logic [7:0]  daddr;    // Pending byte address.
		logic [31:0] rdata;    // Read data.
		logic        ready;    // Bus ready out.
	} tmsq_state_t;

endpackage : tmsq_pkg

// >>> rtl/tmsq_top.sv
// Timer mode sequencer with compare outputs and an AHB-Lite register slave.
`timescale 1ns/100ps
// Notes on behaviour
// - Mode field alone sets the count sequence.
// - Action picks polarity or set/clear/toggle.
// - Route bit gates whether a pin drives.
// - Mode 0 increments and wraps through zero.
// - Normal overflow flag sets at zero, sticky.
// - Normal mode accepts count writes anytime.
// - CTC clears at compare A or capture.
// - CTC TOP unbuffered; missed TOP wraps.
// - CTC TOP sets compare A or capture flag.
// - CTC action one toggles output A.
// - Toggle rate follows prescaler and compare.
// - CTC overflow flag sets at wrap.
// - Modes 5,6,7,14,15 are fast PWM.
// - Fast PWM sets/clears at match and TOP.
// - Fast PWM TOP per mode, clear after.
// - Register TOP spans 0x0003 to 0xFFFF.
// - Fast PWM TOP sets overflow; register TOP also sets its flag.
// - Each channel flags its own match.
// - Fixed TOP masks compare write bits.
// - Compares buffered only in PWM modes.
// - Buffer loads into compare at TOP.
// - Count write blocks next tick matches.
module tmsq_top (
	input  wire logic        clock_i,     // System clock, 10 MHz.
	input  wire logic        rst_n_i,     // Synchronous reset, active low.
	input  wire logic        hsel_i,      // Slave select.
	input  wire logic [31:0] haddr_i,     // Byte address.
	input  wire logic [1:0]  htrans_i,    // Transfer type.
	input  wire logic        hwrite_i,    // Write when high.
	input  wire logic [2:0]  hsize_i,     // Transfer size, word only.
	input  wire logic [31:0] hwdata_i,    // Write data.
	input  wire logic        hready_i,    // Bus ready.
	output logic      [31:0] hrdata_o,    // Read data.
	output logic             hreadyout_o, // Slave ready.
	output logic             hresp_o,     // Response, always OKAY.
	output logic             cmp_a_pin_o, // Compare A pin level.
	output logic             cmp_a_oe_n_o,// Compare A pin enable, low drives.
	output logic             cmp_b_pin_o, // Compare B pin level.
	output logic             cmp_b_oe_n_o // Compare B pin enable, low drives.
);

	// ==========================================================
	// Decoding helpers.

	// Fast PWM modes share one single slope sequence.
	function automatic logic is_fast(input logic [3:0] m);
		is_fast = (m == tmsq_pkg::MODE_FAST_8) || (m == tmsq_pkg::MODE_FAST_9) ||
		          (m == tmsq_pkg::MODE_FAST_10) || (m == tmsq_pkg::MODE_FAST_CAP) ||
		          (m == tmsq_pkg::MODE_FAST_CMP);
	endfunction : is_fast

	// Every mode other than normal, clear on compare A and clear on capture buffers compares.
	function automatic logic is_pwm(input logic [3:0] m);
		is_pwm = (m != tmsq_pkg::MODE_NORMAL) && (m != tmsq_pkg::MODE_CTC_CMPA) &&
		         (m != tmsq_pkg::MODE_CTC_CAPT);
	endfunction : is_pwm

	// Mask of bits that exist at the active resolution.
	function automatic logic [15:0] res_mask(input logic [3:0] m);
		if (m == tmsq_pkg::MODE_FAST_8)
			res_mask = tmsq_pkg::TOP_8BIT;
		else if (m == tmsq_pkg::MODE_FAST_9)
			res_mask = tmsq_pkg::TOP_9BIT;
		else if (m == tmsq_pkg::MODE_FAST_10)
			res_mask = tmsq_pkg::TOP_10BIT;
		else
			res_mask = tmsq_pkg::CNT_MAX;
	endfunction : res_mask

	// Last divider state for each prescaler setting.
	function automatic logic [9:0] div_last(input logic [2:0] p);
		if (p == tmsq_pkg::PSC_8)
			div_last = tmsq_pkg::DIV_8;
		else if (p == tmsq_pkg::PSC_64)
			div_last = tmsq_pkg::DIV_64;
		else if (p == tmsq_pkg::PSC_256)
			div_last = tmsq_pkg::DIV_256;
		else if (p == tmsq_pkg::PSC_1)
			div_last = '0;
		else
			div_last = tmsq_pkg::DIV_1024;
	endfunction : div_last

	// Next compare output state; the match wins over TOP so that a compare
	// equal to TOP gives a constant level, as users of full duty expect.
	function automatic logic wave(input logic oc, input logic [1:0] act,
	                              input logic hit, input logic top, input logic fast,
	                              input logic tgl_ok);
		wave = oc;
		if (!fast)
		begin
			if (hit && act == tmsq_pkg::ACT_TOGGLE)
				wave = !oc;
			else if (hit && act == tmsq_pkg::ACT_CLEAR)
				wave = 1'b0;
			else if (hit && act == tmsq_pkg::ACT_SET)
				wave = 1'b1;
		end
		else if (act == tmsq_pkg::ACT_CLEAR)
		begin
			if (hit)
				wave = 1'b1;
			else if (top)
				wave = 1'b0;
		end
		else if (act == tmsq_pkg::ACT_SET)
		begin
			if (hit)
				wave = 1'b0;
			else if (top)
				wave = 1'b1;
		end
		else if (act == tmsq_pkg::ACT_TOGGLE && tgl_ok && hit)
			wave = !oc;
	endfunction : wave

	// ==========================================================
	// State and combinational signals.
	tmsq_pkg::tmsq_state_t st_r;   // Registered state.
	tmsq_pkg::tmsq_state_t st_nxt; // Next state.
	logic                  tick;   // Timer clock enable.
	logic [15:0]           top;    // Current TOP value.
	logic                  hit_a;  // Compare A match.
	logic                  hit_b;  // Compare B match.
	logic                  at_top; // Counter reached TOP.
	logic                  wr_en;  // Write data phase this cycle.
	logic [3:0]            fl_set; // Flags set by hardware.
	logic [3:0]            fl_clr; // Flags cleared by software.
	logic [15:0]           wval;   // Masked compare write value.

	// ==========================================================
	// Next state: prescaler, counter, flags, outputs and the bus.
	always_comb
	begin
		st_nxt = st_r;
		fl_set = '0;
		fl_clr = '0;
		wr_en  = st_r.dph && st_r.dwr;
		wval   = hwdata_i[15:0] & res_mask(st_r.ctrl.mode);
		// The divider free runs while a prescaler is selected.
		tick = (st_r.ctrl.presc != tmsq_pkg::PSC_STOP) &&
		       (st_r.div >= div_last(st_r.ctrl.presc));
		if (st_r.ctrl.presc == tmsq_pkg::PSC_STOP || tick)
			st_nxt.div = '0;
		else
			st_nxt.div = st_r.div + 10'h001;
		// TOP follows the mode field only.
		if (st_r.ctrl.mode == tmsq_pkg::MODE_CTC_CAPT || st_r.ctrl.mode == tmsq_pkg::MODE_FAST_CAP)
			top = st_r.capt;
		else if (st_r.ctrl.mode == tmsq_pkg::MODE_CTC_CMPA ||
		         st_r.ctrl.mode == tmsq_pkg::MODE_FAST_CMP)
			top = st_r.cmpa_act;
		else if (is_fast(st_r.ctrl.mode))
			top = res_mask(st_r.ctrl.mode);
		else
			top = tmsq_pkg::CNT_MAX;
		// A blocked tick sees no match at all, TOP included.
		hit_a  = (st_r.cnt == st_r.cmpa_act) && !st_r.blk;
		hit_b  = (st_r.cnt == st_r.cmpb_act) && !st_r.blk;
		at_top = (st_r.cnt == top) && !st_r.blk;
		// Counting happens only on a tick; otherwise all holds.
		if (tick)
		begin
			st_nxt.blk = 1'b0;
			fl_set[tmsq_pkg::FLG_CMPA] = hit_a;
			fl_set[tmsq_pkg::FLG_CMPB] = hit_b;
			if (is_fast(st_r.ctrl.mode) && at_top)
			begin
				st_nxt.cnt = tmsq_pkg::CNT_BOTTOM;
				fl_set[tmsq_pkg::FLG_OVF] = 1'b1;
				if (st_r.ctrl.mode == tmsq_pkg::MODE_FAST_CMP)
					fl_set[tmsq_pkg::FLG_CMPA] = 1'b1;
				if (st_r.ctrl.mode == tmsq_pkg::MODE_FAST_CAP)
					fl_set[tmsq_pkg::FLG_CAPT] = 1'b1;
				st_nxt.cmpa_act = st_r.cmpa_buf;
				st_nxt.cmpb_act = st_r.cmpb_buf;
			end
			else if (!is_pwm(st_r.ctrl.mode) && st_r.ctrl.mode != tmsq_pkg::MODE_NORMAL && at_top)
			begin
				// Clear on compare; a TOP below the count is missed and wraps.
				st_nxt.cnt = tmsq_pkg::CNT_BOTTOM;
				if (st_r.ctrl.mode == tmsq_pkg::MODE_CTC_CAPT)
					fl_set[tmsq_pkg::FLG_CAPT] = 1'b1;
				else
					fl_set[tmsq_pkg::FLG_CMPA] = 1'b1;
				fl_set[tmsq_pkg::FLG_OVF] = (st_r.cnt == tmsq_pkg::CNT_MAX);
			end
			else
			begin
				// Plain increment; phase correct codes also fall here.
				st_nxt.cnt = st_r.cnt + tmsq_pkg::CNT_ONE;
				fl_set[tmsq_pkg::FLG_OVF] = (st_r.cnt == tmsq_pkg::CNT_MAX);
				// Unbuilt PWM codes still move their buffers, at the wrap.
				if (is_pwm(st_r.ctrl.mode) && !is_fast(st_r.ctrl.mode) && st_r.cnt == tmsq_pkg::CNT_MAX)
				begin
					st_nxt.cmpa_act = st_r.cmpa_buf;
					st_nxt.cmpb_act = st_r.cmpb_buf;
				end
			end
			st_nxt.oc_a = wave(st_r.oc_a, st_r.ctrl.act_a, hit_a, at_top,
			                   is_fast(st_r.ctrl.mode),
			                   st_r.ctrl.mode == tmsq_pkg::MODE_FAST_CMP);
			st_nxt.oc_b = wave(st_r.oc_b, st_r.ctrl.act_b, hit_b, at_top,
			                   is_fast(st_r.ctrl.mode), 1'b0);
		end
		// Register writes land in the data phase; software wins over counting.
		if (wr_en)
		begin
			if (st_r.daddr == tmsq_pkg::OFS_CTRL)
				st_nxt.ctrl = hwdata_i[tmsq_pkg::CTRL_W-1:0];
			else if (st_r.daddr == tmsq_pkg::OFS_COUNT)
			begin
				st_nxt.cnt = hwdata_i[15:0];
				st_nxt.blk = 1'b1;
			end
			else if (st_r.daddr == tmsq_pkg::OFS_CMPA)
			begin
				st_nxt.cmpa_buf = wval;
				if (!is_pwm(st_r.ctrl.mode))
					st_nxt.cmpa_act = wval;
			end
			else if (st_r.daddr == tmsq_pkg::OFS_CMPB)
			begin
				st_nxt.cmpb_buf = wval;
				if (!is_pwm(st_r.ctrl.mode))
					st_nxt.cmpb_act = wval;
			end
			else if (st_r.daddr == tmsq_pkg::OFS_CAPT)
				st_nxt.capt = hwdata_i[15:0];
			else if (st_r.daddr == tmsq_pkg::OFS_FLAGS)
				fl_clr = hwdata_i[3:0];
		end
		// A flag raised in the cycle of its clear survives.
		st_nxt.flags = (st_r.flags & ~fl_clr) | fl_set;
		// The route bit must be set before an action can reach the pin.
		st_nxt.oe_a_n = !(st_nxt.ctrl.route_a && st_nxt.ctrl.dir_a &&
		                  st_nxt.ctrl.act_a != tmsq_pkg::ACT_NONE);
		st_nxt.oe_b_n = !(st_nxt.ctrl.route_b && st_nxt.ctrl.dir_b &&
		                  st_nxt.ctrl.act_b != tmsq_pkg::ACT_NONE);
		// Address phase; read data is fetched here so no wait state is needed.
		st_nxt.dph   = hsel_i && htrans_i[1] && hready_i;
		st_nxt.dwr   = hwrite_i;
		st_nxt.daddr = haddr_i[7:0];
		st_nxt.rdata = '0;
		if (st_nxt.dph && !hwrite_i)
		begin
			if (haddr_i[7:0] == tmsq_pkg::OFS_CTRL)
				st_nxt.rdata[tmsq_pkg::CTRL_W-1:0] = st_r.ctrl;
			else if (haddr_i[7:0] == tmsq_pkg::OFS_COUNT)
				st_nxt.rdata[15:0] = st_r.cnt;
			else if (haddr_i[7:0] == tmsq_pkg::OFS_CMPA)
				st_nxt.rdata[15:0] = st_r.cmpa_buf;
			else if (haddr_i[7:0] == tmsq_pkg::OFS_CMPB)
				st_nxt.rdata[15:0] = st_r.cmpb_buf;
			else if (haddr_i[7:0] == tmsq_pkg::OFS_CAPT)
				st_nxt.rdata[15:0] = st_r.capt;
			else if (haddr_i[7:0] == tmsq_pkg::OFS_FLAGS)
				st_nxt.rdata[3:0] = st_r.flags;
		end
		st_nxt.ready = 1'b1;
	end

	// ==========================================================
	// State register with synchronous reset.
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			st_r        <= '0;
			st_r.oe_a_n <= 1'b1;
			st_r.oe_b_n <= 1'b1;
			st_r.ready  <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end

	// Outputs other than hresp_o come straight from the state flops.
	assign hrdata_o     = st_r.rdata;
	assign hreadyout_o  = st_r.ready;
	assign hresp_o      = 1'b0;
	assign cmp_a_pin_o  = st_r.oc_a;
	assign cmp_a_oe_n_o = st_r.oe_a_n;
	assign cmp_b_pin_o  = st_r.oc_b;
	assign cmp_b_oe_n_o = st_r.oe_b_n;

	// ==========================================================
	// Assertions.
	AST_NORMAL_WRAP: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		tick && !wr_en && st_r.ctrl.mode == tmsq_pkg::MODE_NORMAL && st_r.cnt == 16'hFFFF
		|=> st_r.cnt == 16'h0000 && st_r.flags[0])
		else $error("Normal mode did not wrap with overflow.");
	AST_OVF_STICKY: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		st_r.flags[0] && !(wr_en && st_r.daddr == tmsq_pkg::OFS_FLAGS) |=> st_r.flags[0])
		else $error("Overflow flag dropped without a clear.");
	AST_CTC_CLEAR: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		tick && !wr_en && st_r.ctrl.mode == tmsq_pkg::MODE_CTC_CMPA && hit_a
		|=> st_r.cnt == 16'h0000 && st_r.flags[1])
		else $error("Clear on compare failed.");
	AST_FAST_TOP: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		tick && !wr_en && st_r.ctrl.mode == tmsq_pkg::MODE_FAST_8 && !st_r.blk &&
		st_r.cnt == 16'h00FF |=> st_r.cnt == 16'h0000 && st_r.flags[0])
		else $error("Fast PWM fixed TOP not honoured.");
	AST_BUF_LOAD: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		tick && !wr_en && st_r.ctrl.mode == tmsq_pkg::MODE_FAST_CMP && at_top
		|=> st_r.cmpa_act == $past(st_r.cmpa_buf) && st_r.flags[1])
		else $error("Compare buffer not loaded at TOP.");
	AST_BLOCK: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		st_r.blk && tick && !st_r.flags[1] |=> !st_r.flags[1])
		else $error("Match seen in a blocked tick.");
	AST_HOLD: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		!tick && !wr_en |=> $stable(st_r.cnt) && $stable(st_r.oc_a))
		else $error("Counter moved without a tick.");
	AST_PIN_GATE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		!st_r.ctrl.route_a |-> cmp_a_oe_n_o)
		else $error("Pin A driven without its route bit.");
	AST_MASK: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		wr_en && st_r.daddr == tmsq_pkg::OFS_CMPA && st_r.ctrl.mode == tmsq_pkg::MODE_FAST_8
		|=> st_r.cmpa_buf[15:8] == 8'h00)
		else $error("Compare write not masked.");
	AST_DIRECT: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		wr_en && st_r.daddr == tmsq_pkg::OFS_CMPA && !is_pwm(st_r.ctrl.mode)
		|=> st_r.cmpa_act == st_r.cmpa_buf)
		else $error("Compare A not written directly.");
	AST_TOGGLE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		tick && st_r.ctrl.mode == tmsq_pkg::MODE_CTC_CMPA && st_r.ctrl.act_a == 2'h1 && hit_a
		|=> cmp_a_pin_o != $past(cmp_a_pin_o))
		else $error("Output A did not toggle.");
	AST_PWM_SET: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		tick && st_r.ctrl.mode == tmsq_pkg::MODE_FAST_CAP && st_r.ctrl.act_a == 2'h2 && hit_a
		|=> cmp_a_pin_o)
		else $error("Non-inverted PWM not set on match.");
	COV_CTC: cover property (@(posedge clock_i) disable iff (!rst_n_i)
		st_r.ctrl.mode == tmsq_pkg::MODE_CTC_CAPT && tick && at_top);
	COV_FAST: cover property (@(posedge clock_i) disable iff (!rst_n_i)
		st_r.ctrl.mode == tmsq_pkg::MODE_FAST_CMP && tick && at_top);
	COV_WRAP: cover property (@(posedge clock_i) disable iff (!rst_n_i)
		tick && st_r.cnt == 16'hFFFF);

endmodule : tmsq_top

// >>> tb/timer16_mode_sequencer_bench.sv
// Self-checking testbench for the timer mode sequencer and its register slave.
`timescale 1ns/100ps
module timer16_mode_sequencer_bench;
	// ==========================================================
	// Stimulus, response and bookkeeping.
	logic        clock_i   = 1'b0;          // 10 MHz clock.
	logic        rst_n_i   = 1'b0;          // Reset, active low.
	logic        hsel_i    = 1'b0;          // Slave select.
	logic [31:0] haddr_i   = 32'h00000000;  // Byte address.
	logic [1:0]  htrans_i  = 2'h0;          // Transfer type.
	logic        hwrite_i  = 1'b0;          // Write strobe.
	logic [31:0] hwdata_i  = 32'h00000000;  // Write data.
	wire  logic  hready_w;                  // Single slave, so its ready is the bus ready.
	wire  logic [31:0] hrdata_o;            // Read data.
	wire  logic  cmp_a_pin_o, cmp_a_oe_n_o, cmp_b_pin_o, cmp_b_oe_n_o, hresp_o; // Pins, response.
	int          n_fail    = 0;             // Mismatches.
	int          tests_run = 0;             // Comparisons.
	logic [31:0] seed      = 32'h00004A2D;  // Fixed seed keeps runs repeatable.
	logic [3:0]  pwm_modes [5] = '{4'h5, 4'h6, 4'h7, 4'hE, 4'hF}; // Single-slope modes.
	int          dv [5] = '{1, 8, 64, 256, 1024}; // Divide factor of prescaler codes 1 to 5.

	// Clock with a 100 ns period.
	always #50 clock_i = ~clock_i;

	tmsq_top dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
		.hready_i(hready_w), .hrdata_o(hrdata_o), .hreadyout_o(hready_w), .hresp_o(hresp_o),
		.cmp_a_pin_o(cmp_a_pin_o), .cmp_a_oe_n_o(cmp_a_oe_n_o),
		.cmp_b_pin_o(cmp_b_pin_o), .cmp_b_oe_n_o(cmp_b_oe_n_o));

	// ==========================================================
	// Helpers: random source, control word builder, TOP per mode.
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// Route and direction bits of both channels follow en together.
	function automatic logic [31:0] mk(input logic [3:0] m, input logic [1:0] aa,
		input logic [1:0] ab, input logic en, input logic [2:0] p);
		tmsq_pkg::tmsq_ctrl_t c;
		c = '{presc: p, dir_b: en, dir_a: en, route_b: en, route_a: en,
			act_b: ab, act_a: aa, mode: m};
		return {17'h00000, c};
	endfunction : mk

	// Modes without a fixed TOP return the register value handed in.
	function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] capt,
		input logic [15:0] ca);
		case (m)
			tmsq_pkg::MODE_FAST_8:   return tmsq_pkg::TOP_8BIT;
			tmsq_pkg::MODE_FAST_9:   return tmsq_pkg::TOP_9BIT;
			tmsq_pkg::MODE_FAST_10:  return tmsq_pkg::TOP_10BIT;
			tmsq_pkg::MODE_FAST_CAP: return capt;
			default:                 return ca;
		endcase
	endfunction : top_of

	// ==========================================================
	// Verdict, comparison and bus tasks.
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
		begin
			$display("Test passed");
		end
		else
		begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Bounded wait for ready; a hang ends the run as a failure.
	task automatic wait_rdy();
		int k;
		k = 0;
		@(posedge clock_i);
		while (hready_w !== 1'b1)
		begin
			k++;
			if (k > 16)
			begin
				n_fail++;
				stop_test();
			end
			@(posedge clock_i);
		end
	endtask : wait_rdy

	// One single transfer: address phase, then data phase; entered just after an edge.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel_i   <= 1'b1;
		haddr_i  <= {24'h000000, a};
		htrans_i <= 2'h2;
		hwrite_i <= wr;
		wait_rdy();
		hsel_i   <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= wd;
		wait_rdy();
		rd = hrdata_o;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask : wr

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h00000000, x);
		chk(x, e);
	endtask : rchk

	// Counts high samples of one pin over w consecutive cycles.
	task automatic hi_count(input int w, input logic b, output int h);
		h = 0;
		repeat (w)
		begin
			@(posedge clock_i);
			h += int'(((b ? cmp_b_pin_o : cmp_a_pin_o) === 1'b1));
		end
	endtask : hi_count

	// ==========================================================
	// Main sequence.
	initial
	begin
		logic [31:0] v;
		logic [15:0] n, t, cb, tp;
		logic [1:0]  act;
		int          h;
		repeat (16) @(posedge clock_i);
		rst_n_i <= 1'b1;
		// Reset state, then an unmapped place that must read zero after a write.
		chk({27'h0, hresp_o, cmp_a_oe_n_o, cmp_b_oe_n_o, cmp_a_pin_o, cmp_b_pin_o}, 32'hC);
		wr(8'h18, rnd());
		for (int a = 0; a <= 24; a += 4)
		begin
			rchk(8'(a), 32'h00000000);
		end
		// Compare writes: direct in mode 0, masked to the resolution in fixed-TOP modes.
		for (int i = 0; i < 4; i++)
		begin
			wr(tmsq_pkg::OFS_CTRL, mk((i == 0) ? 4'h0 : pwm_modes[i-1], 2'h0, 2'h0, 1'b0, 3'h0));
			v = rnd();
			wr(tmsq_pkg::OFS_CMPA, v);
			rchk(tmsq_pkg::OFS_CMPA, {16'h0000, v[15:0] & top_of((i == 0) ? 4'h0 : pwm_modes[i-1], 16'h0000, 16'hFFFF)});
			wr(tmsq_pkg::OFS_COUNT, v);
			rchk(tmsq_pkg::OFS_COUNT, {16'h0000, v[15:0]});
		end
		// A count write equal to compare A blocks that match once the timer starts.
		wr(tmsq_pkg::OFS_CTRL, mk(4'h0, 2'h0, 2'h0, 1'b0, 3'h0));
		// Kept at or above 0x100 so the wrap scenario below never meets it.
		v = (rnd() & 32'h00000FFF) | 32'h00000100;
		wr(tmsq_pkg::OFS_CMPA, v);
		wr(tmsq_pkg::OFS_COUNT, v);
		wr(tmsq_pkg::OFS_FLAGS, 32'hF);
		wr(tmsq_pkg::OFS_CTRL, mk(4'h0, 2'h0, 2'h0, 1'b0, 3'h1));
		// Let the blocked tick and one more pass before the flags are read.
		repeat (2) @(posedge clock_i);
		rchk(tmsq_pkg::OFS_FLAGS, 32'h0);
		// Normal mode wraps through zero, overflow sticks until written one.
		wr(tmsq_pkg::OFS_CTRL, mk(4'h0, 2'h0, 2'h0, 1'b0, 3'h0));
		wr(tmsq_pkg::OFS_COUNT, 32'hFFF8);
		wr(tmsq_pkg::OFS_FLAGS, 32'hF);
		wr(tmsq_pkg::OFS_CTRL, mk(4'h0, 2'h0, 2'h0, 1'b0, 3'h1));
		repeat (20) @(posedge clock_i);
		wr(tmsq_pkg::OFS_CTRL, mk(4'h0, 2'h0, 2'h0, 1'b0, 3'h0));
		bus(1'b0, tmsq_pkg::OFS_COUNT, 32'h0, v);
		chk({31'h0, v[15:0] < 16'h0040}, 32'h1);
		repeat (10) @(posedge clock_i);
		rchk(tmsq_pkg::OFS_FLAGS, 32'h5);
		wr(tmsq_pkg::OFS_FLAGS, 32'h1);
		rchk(tmsq_pkg::OFS_FLAGS, 32'h4);
		// Clear on compare A with toggle, once per prescaler code: a half period is
		// compare A plus one ticks, each tick the divide factor of clocks long.
		n = 16'h0003 + 16'(rnd() % 8);
		wr(tmsq_pkg::OFS_CMPA, {16'h0000, n});
		for (int p = 1; p <= 5; p++)
		begin
			wr(tmsq_pkg::OFS_COUNT, 32'h0);
			wr(tmsq_pkg::OFS_FLAGS, 32'hF);
			wr(tmsq_pkg::OFS_CTRL, mk(4'h4, 2'h1, 2'h0, 1'b1, 3'(p)));
			hi_count(2 * (n + 1) * dv[p-1], 1'b0, h);
			chk(32'(h), 32'(n + 1) * 32'(dv[p-1]));
			chk({31'h0, cmp_a_oe_n_o}, 32'h0);
			wr(tmsq_pkg::OFS_CTRL, mk(4'h4, 2'h1, 2'h0, 1'b0, 3'h0));
			rchk(tmsq_pkg::OFS_FLAGS, 32'h6);
			chk({31'h0, cmp_a_oe_n_o}, 32'h1);
		end
		// Clear on capture with the count already past TOP: it must wrap first.
		wr(tmsq_pkg::OFS_CAPT, {16'h0000, n});
		wr(tmsq_pkg::OFS_COUNT, 32'hFFF0);
		wr(tmsq_pkg::OFS_FLAGS, 32'hF);
		wr(tmsq_pkg::OFS_CTRL, mk(4'hC, 2'h0, 2'h0, 1'b0, 3'h1));
		repeat (40) @(posedge clock_i);
		wr(tmsq_pkg::OFS_CTRL, mk(4'hC, 2'h0, 2'h0, 1'b0, 3'h0));
		rchk(tmsq_pkg::OFS_FLAGS, 32'hF);
		bus(1'b0, tmsq_pkg::OFS_COUNT, 32'h0, v);
		chk({31'h0, v[15:0] <= n}, 32'h1);
		// Single-slope modes: duty of channel B over one whole period, both polarities.
		for (int i = 0; i < 5; i++)
		begin
			t = (i == 3) ? 16'h0003 : 16'h0003 + 16'(rnd() % 37);
			wr(tmsq_pkg::OFS_CTRL, mk(pwm_modes[i], 2'h0, 2'h0, 1'b1, 3'h0));
			wr(tmsq_pkg::OFS_CAPT, {16'h0000, t});
			wr(tmsq_pkg::OFS_CMPA, {16'h0000, t});
			tp = top_of(pwm_modes[i], t, t);
			cb = 16'(rnd() % tp);
			act = (i % 2 == 0) ? tmsq_pkg::ACT_SET : tmsq_pkg::ACT_CLEAR;
			wr(tmsq_pkg::OFS_CMPB, {16'h0000, cb});
			wr(tmsq_pkg::OFS_COUNT, 32'h0);
			wr(tmsq_pkg::OFS_FLAGS, 32'hF);
			wr(tmsq_pkg::OFS_CTRL, mk(pwm_modes[i], act, act, 1'b1, 3'h1));
			repeat (2 * tp + 12) @(posedge clock_i);
			hi_count(tp + 1, 1'b1, h);
			chk(32'(h), (act == tmsq_pkg::ACT_CLEAR) ? 32'(tp - cb) : 32'(cb + 1));
			chk({31'h0, cmp_b_oe_n_o}, 32'h0);
			wr(tmsq_pkg::OFS_CTRL, mk(pwm_modes[i], act, act, 1'b1, 3'h0));
			rchk(tmsq_pkg::OFS_FLAGS, (pwm_modes[i] == 4'hE) ? 32'hF : 32'h7);
		end
		stop_test();
	end

endmodule : timer16_mode_sequencer_bench
